// File: rtl/stsc_cfg.svh
`ifndef STSC_CFG_SVH
`define STSC_CFG_SVH

// register offsets
`define STSC_ADDR_INPUT_EN   8'h40
`define STSC_ADDR_SCAN_CFG   8'h41
`define STSC_ADDR_SENS       8'h42
`define STSC_ADDR_THRESHOLD  8'h43
`define STSC_ADDR_EVT_STATUS 8'h44
`define STSC_ADDR_EVT_MASK   8'h45
`define STSC_ADDR_TOUCH      8'h46

// reset values
`define STSC_RST_INPUT_EN    8'h00
`define STSC_RST_SCAN_CFG    8'h39
`define STSC_RST_SENS        8'h02
`define STSC_RST_THRESHOLD   8'h40
`define STSC_RST_EVT_MASK    8'h00

// field positions
`define STSC_INPUT_EN_MSB    5
`define STSC_ACC_BIT         7
`define STSC_AVG_MSB         6
`define STSC_AVG_LSB         4
`define STSC_SAMP_MSB        3
`define STSC_SAMP_LSB        2
`define STSC_CYC_MSB         1
`define STSC_CYC_LSB         0
`define STSC_GAIN_MSB        2
`define STSC_THR_MSB         6
`define STSC_EVT_OVERRUN     6

// timing: base sample time and base cycle time, both scaled by their codes
`define STSC_CLK_MHZ         200
`define STSC_SAMP_BASE_US    320
`define STSC_CYC_BASE_MS     35
`define STSC_SAMP_BASE_CYC   (`STSC_SAMP_BASE_US * `STSC_CLK_MHZ)
`define STSC_CYC_BASE_CYC    (`STSC_CYC_BASE_MS * 1000 * `STSC_CLK_MHZ)

`endif

// File: rtl/stsc_pkg.sv
package stsc_pkg;

    // scan sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PICK,
        ST_SAMPLE,
        ST_COMBINE,
        ST_WAIT
    } stsc_fsm_t;

    // request to the sensing front end
    typedef struct packed {
        logic       active;
        logic [2:0] sel;
    } stsc_sense_t;

    // whole state of the main module
    typedef struct packed {
        logic [7:0]         input_en;
        logic [7:0]         scan_cfg;
        logic [7:0]         sens;
        logic [7:0]         threshold;
        logic [6:0]         evt_status;
        logic [6:0]         evt_mask;
        logic [5:0]         touch;
        logic [7:0]         rdata;
        stsc_fsm_t          fsm;
        logic [2:0]         ch;
        logic [7:0]         nsamp;
        logic [31:0]        samp_tmr;
        logic [31:0]        cyc_cnt;
        logic signed [23:0] acc;
    } stsc_state_t;

endpackage

// File: rtl/stsc_delta.sv
// turns the accumulated per-sample deltas of one input into the 7-bit scaled delta
module stsc_delta (
    input  wire logic signed [23:0] acc,
    input  wire logic [2:0]         avg_code,
    input  wire logic               accumulate_mode,
    input  wire logic [2:0]         standby_gain_select,
    output logic [6:0]              delta
);

    logic signed [23:0] raw;
    logic signed [23:0] scaled;

    // average or sum, then gain; the shift by the gain code makes bit 6 weigh 64 << code raw counts
    always_comb begin
        raw    = accumulate_mode ? acc : (acc >>> avg_code);
        scaled = raw >>> standby_gain_select;
        // clamp instead of wrap, negative deltas never count as a touch
        if (scaled < 0) begin
            delta = 7'h00;
        end else if (scaled > 24'sh00007f) begin
            delta = 7'h7f;
        end else begin
            delta = scaled[6:0];
        end
    end

endmodule // stsc_delta

// File: rtl/stsc_top.sv
`include "stsc_cfg.svh"

// standby scan sequencer with its configuration registers
module stsc_top #(
    parameter logic [31:0] SAMP_BASE_CYC = `STSC_SAMP_BASE_CYC,
    parameter logic [31:0] CYC_BASE_CYC  = `STSC_CYC_BASE_CYC
) (
    input  wire logic                mclk,
    input  wire logic                reset_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [7:0]               reg_rdata,
    input  wire logic                standby,
    input  wire logic [15:0]         sense_count,
    input  wire logic [5:0][15:0]    base_count,
    output stsc_pkg::stsc_sense_t    sense_req,
    output logic [5:0]               touch,
    output logic                     wake,
    output logic                     irq
);

    stsc_pkg::stsc_state_t q;
    stsc_pkg::stsc_state_t d;

    // decoded configuration fields
    logic [5:0]         en_bits;
    logic               accumulate_mode;
    logic [2:0]         standby_sample_count;
    logic [1:0]         standby_sample_duration;
    logic [1:0]         standby_cycle_period;
    logic [2:0]         standby_gain_select;
    logic [6:0]         thr;

    // derived lengths and helpers
    logic [31:0]        samp_len;
    logic [31:0]        cyc_len;
    logic [7:0]         last_samp;
    logic [16:0]        samp_diff;
    logic signed [23:0] acc_next;
    logic [6:0]         delta;
    logic               hit;
    logic [6:0]         evt_set;
    logic [6:0]         evt_clr;

    // field decode straight from the registers
    assign en_bits                 = q.input_en[`STSC_INPUT_EN_MSB:0];
    assign accumulate_mode         = q.scan_cfg[`STSC_ACC_BIT];
    assign standby_sample_count    = q.scan_cfg[`STSC_AVG_MSB:`STSC_AVG_LSB];
    assign standby_sample_duration = q.scan_cfg[`STSC_SAMP_MSB:`STSC_SAMP_LSB];
    assign standby_cycle_period    = q.scan_cfg[`STSC_CYC_MSB:`STSC_CYC_LSB];
    assign standby_gain_select     = q.sens[`STSC_GAIN_MSB:0];
    assign thr                     = q.threshold[`STSC_THR_MSB:0];

    // sample length doubles per code step: 320us, 640us, 1.28ms, 2.56ms
    assign samp_len = SAMP_BASE_CYC << standby_sample_duration;

    // cycle length grows linearly: 35ms, 70ms, 105ms, 140ms
    assign cyc_len = 32'(CYC_BASE_CYC * (32'(standby_cycle_period) + 32'h00000001));

    // index of the last sample of a measurement, 2**code minus one
    assign last_samp = 8'((9'h001 << standby_sample_count) - 9'h001);

    // one sample minus the stored base count of the input under test
    assign samp_diff = {1'b0, sense_count} - {1'b0, base_count[q.ch]};

    // sign extend the difference into the running sum
    assign acc_next = q.acc + {{7{samp_diff[16]}}, samp_diff};

    // scaling of the combined result, standby settings only
    stsc_delta u_delta (
        .acc                 (q.acc),
        .avg_code            (standby_sample_count),
        .accumulate_mode     (accumulate_mode),
        .standby_gain_select (standby_gain_select),
        .delta               (delta)
    );

    // the standby threshold decides, not the per-input normal thresholds
    assign hit = (delta > thr);

    // next state: register access, event flags and the scan sequencer
    always_comb begin
        d       = q;
        evt_set = 7'h00;
        evt_clr = 7'h00;

        // read data stands for exactly one cycle after the strobe
        d.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `STSC_ADDR_INPUT_EN:   d.rdata = {2'b00, q.input_en[5:0]};
                `STSC_ADDR_SCAN_CFG:   d.rdata = q.scan_cfg;
                `STSC_ADDR_SENS:       d.rdata = {5'b00000, q.sens[2:0]};
                `STSC_ADDR_THRESHOLD:  d.rdata = {1'b0, q.threshold[6:0]};
                `STSC_ADDR_EVT_STATUS: d.rdata = {1'b0, q.evt_status};
                `STSC_ADDR_EVT_MASK:   d.rdata = {1'b0, q.evt_mask};
                `STSC_ADDR_TOUCH:      d.rdata = {2'b00, q.touch};
                default:               d.rdata = 8'h00;
            endcase
        end

        // writes; unused bits are stored as zero so they read back as zero
        if (reg_wr) begin
            unique case (reg_addr)
                `STSC_ADDR_INPUT_EN:   d.input_en  = {2'b00, reg_wdata[5:0]};
                `STSC_ADDR_SCAN_CFG:   d.scan_cfg  = reg_wdata;
                `STSC_ADDR_SENS:       d.sens      = {5'b00000, reg_wdata[2:0]};
                `STSC_ADDR_THRESHOLD:  d.threshold = {1'b0, reg_wdata[6:0]};
                `STSC_ADDR_EVT_STATUS: evt_clr     = reg_wdata[6:0];
                `STSC_ADDR_EVT_MASK:   d.evt_mask  = reg_wdata[6:0];
                default:               d.evt_mask  = q.evt_mask;
            endcase
        end

        // the cycle clock runs whenever a scan is under way, saturating so it never wraps
        if (q.fsm != stsc_pkg::ST_IDLE && q.cyc_cnt != 32'hffffffff) begin
            d.cyc_cnt = q.cyc_cnt + 32'h00000001;
        end

        unique case (q.fsm)
            // outside standby no new burst starts, and idle clears every touch flag
            stsc_pkg::ST_IDLE: begin
                d.touch = 6'h00;
                if (standby && en_bits != 6'h00) begin
                    d.cyc_cnt = 32'h00000000;
                    d.ch      = 3'h0;
                    d.fsm     = stsc_pkg::ST_PICK;
                end
            end

            // walk the inputs in order, skipping the ones not enabled
            stsc_pkg::ST_PICK: begin
                if (!standby) begin
                    d.fsm = stsc_pkg::ST_IDLE;
                end else if (q.ch == 3'h6) begin
                    d.fsm = stsc_pkg::ST_WAIT;
                end else if (en_bits[q.ch]) begin
                    d.samp_tmr = samp_len - 32'h00000001;
                    d.nsamp    = 8'h00;
                    d.acc      = 24'sh000000;
                    d.fsm      = stsc_pkg::ST_SAMPLE;
                end else begin
                    d.ch = q.ch + 3'h1;
                end
            end

            // one sample per timer run; the count is taken at the end of the window
            stsc_pkg::ST_SAMPLE: begin
                if (q.samp_tmr != 32'h00000000) begin
                    d.samp_tmr = q.samp_tmr - 32'h00000001;
                end else begin
                    d.acc = acc_next;
                    if (q.nsamp == last_samp) begin
                        d.fsm = stsc_pkg::ST_COMBINE;
                    end else begin
                        // stay on the same input until its samples are all in
                        d.nsamp    = q.nsamp + 8'h01;
                        d.samp_tmr = samp_len - 32'h00000001;
                    end
                end
            end

            // result is updated only once the whole measurement is combined
            stsc_pkg::ST_COMBINE: begin
                d.touch[q.ch] = hit;
                if (hit && !q.touch[q.ch]) begin
                    evt_set[q.ch] = 1'b1;
                end
                d.ch  = q.ch + 3'h1;
                d.fsm = stsc_pkg::ST_PICK;
            end

            // low power rest of the cycle; an overrun restarts at once
            stsc_pkg::ST_WAIT: begin
                if (!standby) begin
                    d.fsm = stsc_pkg::ST_IDLE;
                end else if (q.cyc_cnt >= cyc_len - 32'h00000001) begin
                    // sampling ran past the cycle: the cycle was stretched, not cut
                    if (q.cyc_cnt >= cyc_len) begin
                        evt_set[`STSC_EVT_OVERRUN] = 1'b1;
                    end
                    d.cyc_cnt = 32'h00000000;
                    d.ch      = 3'h0;
                    d.fsm     = (en_bits != 6'h00) ? stsc_pkg::ST_PICK : stsc_pkg::ST_IDLE;
                end
            end
        endcase

        // sticky events: a set in the same cycle as a clear survives
        d.evt_status = (q.evt_status & ~evt_clr) | evt_set;
    end

    // every field runs from the same clock; reset loads only constants
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            q           <= '0;
            q.input_en  <= `STSC_RST_INPUT_EN;
            q.scan_cfg  <= `STSC_RST_SCAN_CFG;
            q.sens      <= `STSC_RST_SENS;
            q.threshold <= `STSC_RST_THRESHOLD;
            q.evt_mask  <= 7'(`STSC_RST_EVT_MASK);
        end else begin
            q <= d;
        end
    end

    // outputs decoded from registered state
    assign reg_rdata        = q.rdata;
    assign sense_req.active = (q.fsm == stsc_pkg::ST_SAMPLE);
    assign sense_req.sel    = q.ch;
    assign touch            = q.touch;
    assign wake             = |q.touch;
    assign irq              = |(q.evt_status & q.evt_mask);

endmodule // stsc_top

// File: dv/stsc_top_checker.sv
// watches the scan sequencer and register port from the outside
module stsc_top_checker #(
    parameter logic [31:0] SAMP_BASE_CYC = 32'h4,
    parameter logic [31:0] CYC_BASE_CYC  = 32'hc8
) (
    input wire logic                  mclk,
    input wire logic                  reset_n,
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  standby,
    input wire logic [15:0]           sense_count,
    input wire logic [5:0][15:0]      base_count,
    input wire stsc_pkg::stsc_sense_t sense_req,
    input wire logic [5:0]            touch,
    input wire logic                  wake,
    input wire logic                  irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // a window opens and must stay open for the shortest sample length (4 with the small bench base)
    sequence s_open;
        $rose(sense_req.active);
    endsequence
    sequence s_hold;
        sense_req.active [*4];
    endsequence
    a_window_min: assert property (s_open |-> s_hold)
        else $error("sample window shorter than one sample time");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the read answer cycle");
    a_enable_read: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata[7:6] == 2'h0)
        else $error("unused enable bits read nonzero");
    a_gain_read: assert property (reg_rd && reg_addr == 8'h42 |=> reg_rdata[7:3] == 5'h00)
        else $error("unused gain bits read nonzero");
    a_thr_read: assert property (reg_rd && reg_addr == 8'h43 |=> reg_rdata[7] == 1'b0)
        else $error("threshold bit 7 read nonzero");
    a_wake_or: assert property (wake == (|touch))
        else $error("wake differs from the touch flags");
    a_sel_range: assert property (sense_req.active |-> sense_req.sel <= 3'h5)
        else $error("sampled input index out of range");
    a_sel_steady: assert property (sense_req.active && $past(sense_req.active) |-> $stable(sense_req.sel))
        else $error("input changed inside a sampling burst");
    a_touch_after: assert property ((touch & ~$past(touch)) != 6'h00 |-> $past(sense_req.active, 2))
        else $error("touch flag rose without a finished sample");
    a_idle_quiet: assert property (!standby && !sense_req.active |=> !sense_req.active)
        else $error("sampling started outside standby");
endmodule // stsc_top_checker

// File: dv/stsc_frontend_model.sv
// sensing front end: the count stands for the whole window at base plus the pad's offset
module stsc_frontend_model (
    input  wire logic                  mclk,
    input  wire stsc_pkg::stsc_sense_t sense_req,
    input  wire logic [5:0][15:0]      base_count,
    input  wire logic [5:0][15:0]      offset,
    output logic [15:0]                sense_count
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] last_q;

    // outside a window the front end is off, so the count toggles rather than holding a stale value
    always_comb begin
        if (sense_req.active) begin
            sense_count = base_count[sense_req.sel] + offset[sense_req.sel];
        end else begin
            sense_count = ~last_q;
        end
    end

    always_ff @(posedge mclk) begin
        last_q <= sense_count;
    end
endmodule // stsc_frontend_model

// File: dv/stsc_top_bench.sv
module stsc_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] SAMP = 32'h4;
    localparam logic [31:0] CYC  = 32'hc8;
    logic                  mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, standby = 1'b0;
    logic [7:0]            reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [15:0]           sense_count;
    logic [5:0][15:0]      base_count = {6{16'h03e8}}, offs = '0;
    stsc_pkg::stsc_sense_t sense_req;
    logic [5:0]            touch;
    logic                  wake, irq, rd_pend = 1'b0;
    logic [7:0]            exp_q[$];
    int                    error_cnt = 0, samples_checked = 0;

    stsc_top #(.SAMP_BASE_CYC(SAMP), .CYC_BASE_CYC(CYC)) dut_u (.mclk(mclk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .standby(standby), .sense_count(sense_count), .base_count(base_count), .sense_req(sense_req),
        .touch(touch), .wake(wake), .irq(irq));
    stsc_frontend_model pad_u (.mclk(mclk), .sense_req(sense_req), .base_count(base_count), .offset(offs),
        .sense_count(sense_count));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic end_of_test();
        if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic cmp_bit(logic got, logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmp_byte(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_cnt(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    // read data stands only in the cycle after the strobe, so the oldest note is matched there
    always @(posedge mclk) begin
        if (rd_pend) cmp_byte(reg_rdata, exp_q.pop_front());
        rd_pend = reg_rd;
    end

    // one bus cycle; for a read, d is the value expected back
    task automatic op(logic w, logic r, logic [7:0] a, logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) exp_q.push_back(d);
        @(posedge mclk);
    endtask

    task automatic idle(int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    // restart the scan with cleared events; done once the top input's burst has closed
    // a burst under way is not cut by standby, so it is waited out before the sequencer idles
    task automatic measure(logic [2:0] top, logic [31:0] exp_act);
        int k;
        int low;
        int act;
        logic [2:0] last;
        standby <= 1'b0;
        k = 0;
        idle(1);
        while (sense_req.active === 1'b1 && k < 8000) begin
            idle(1);
            k++;
        end
        idle(2);
        op(1'b1, 1'b0, 8'h44, 8'h7f);
        standby <= 1'b1;
        low = 0;
        act = 0;
        last = 3'h7;
        while (!(low >= 2 && last == top) && k < 8000) begin
            idle(1);
            k++;
            if (sense_req.active === 1'b1) begin
                last = sense_req.sel;
                low = 0;
                act++;
            end else low++;
        end
        if (k >= 8000) begin
            error_cnt++;
            $display("BAD %0t scan never finished", $time);
        end
        cmp_cnt(act, exp_act);
    endtask

    // cycles from one burst start to the next; a cycle whose sampling fits keeps its programmed length
    task automatic cycle_chk(logic [31:0] exp_len);
        int k;
        int n;
        int rises;
        logic was;
        k = 0;
        n = 0;
        rises = 0;
        was = 1'b1;
        while (rises < 2 && k < 8000) begin
            idle(1);
            k++;
            if (rises == 1) n++;
            if (sense_req.active === 1'b1 && !was) rises++;
            was = sense_req.active;
        end
        cmp_cnt(n, exp_len);
    endtask

    initial begin
        #400us;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        int r, t, g;
        logic [5:0] et;
        r = $urandom(2);
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        op(1'b0, 1'b1, 8'h40, 8'h00);
        op(1'b0, 1'b1, 8'h41, 8'h39);
        op(1'b0, 1'b1, 8'h42, 8'h02);
        op(1'b0, 1'b1, 8'h43, 8'h40);
        op(1'b0, 1'b1, 8'h47, 8'h00);
        // random values read back through the unused-bit masks, back to back
        r = $urandom();
        op(1'b1, 1'b0, 8'h40, r[7:0]);
        op(1'b0, 1'b1, 8'h40, r[7:0] & 8'h3f);
        op(1'b1, 1'b0, 8'h42, r[15:8]);
        op(1'b0, 1'b1, 8'h42, r[15:8] & 8'h07);
        op(1'b1, 1'b0, 8'h43, r[23:16]);
        op(1'b0, 1'b1, 8'h43, r[23:16] & 8'h7f);
        op(1'b1, 1'b0, 8'h41, r[31:24]);
        op(1'b0, 1'b1, 8'h41, r[31:24]);
        // gain sweep on input 0 alone; the other pads carry a touch but are not scanned
        offs <= {6{16'h00c8}};
        op(1'b1, 1'b0, 8'h40, 8'h01);
        op(1'b1, 1'b0, 8'h41, 8'h10);
        op(1'b1, 1'b0, 8'h43, 8'h14);
        for (g = 0; g < 8; g++) begin
            op(1'b1, 1'b0, 8'h42, g[7:0]);
            measure(3'h0, 2 * SAMP);
            op(1'b0, 1'b1, 8'h46, {7'h00, (32'hc8 >> g) > 32'h14});
            cmp_bit(wake, (32'hc8 >> g) > 32'h14);
        end
        // two samples of 15: the average stays under 20, a proximity-style sum passes
        op(1'b1, 1'b0, 8'h42, 8'h00);
        op(1'b1, 1'b0, 8'h41, 8'h1c);
        offs <= {6{16'h000f}};
        measure(3'h0, 2 * (SAMP << 3));
        op(1'b0, 1'b1, 8'h46, 8'h00);
        op(1'b1, 1'b0, 8'h41, 8'h94);
        measure(3'h0, 2 * (SAMP << 1));
        op(1'b0, 1'b1, 8'h46, 8'h01);
        // the rising flag sets its event; mask raises the line, write-one clears it
        op(1'b0, 1'b1, 8'h44, 8'h01);
        cmp_bit(irq, 1'b0);
        op(1'b1, 1'b0, 8'h45, 8'h01);
        idle(2);
        cmp_bit(irq, 1'b1);
        op(1'b1, 1'b0, 8'h44, 8'h01);
        idle(2);
        cmp_bit(irq, 1'b0);
        // count below base must saturate at zero, not wrap past a zero threshold
        offs <= {6{16'hffce}};
        op(1'b1, 1'b0, 8'h41, 8'h1b);
        op(1'b1, 1'b0, 8'h43, 8'h00);
        measure(3'h0, 2 * (SAMP << 2));
        op(1'b0, 1'b1, 8'h46, 8'h00);
        // longest cycle code: the sampling fits, so bursts start a full cycle apart
        cycle_chk(4 * CYC);
        // all six inputs at 128 samples each outlast the shortest cycle
        t = $urandom_range(100);
        for (g = 0; g < 6; g++) begin
            r = $urandom_range(127);
            offs[g] <= r[15:0];
            et[g] = r > t;
        end
        op(1'b1, 1'b0, 8'h40, 8'h3f);
        op(1'b1, 1'b0, 8'h41, 8'h70);
        op(1'b1, 1'b0, 8'h43, t[7:0]);
        measure(3'h5, 6 * 128 * SAMP);
        op(1'b0, 1'b1, 8'h46, {2'h0, et});
        cmp_byte({2'h0, touch}, {2'h0, et});
        op(1'b0, 1'b1, 8'h44, {2'h1, et});
        idle(2);
        end_of_test();
    end
endmodule // stsc_top_bench

bind stsc_top stsc_top_checker #(.SAMP_BASE_CYC(SAMP_BASE_CYC), .CYC_BASE_CYC(CYC_BASE_CYC)) chk_u (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby(standby), .sense_count(sense_count),
    .base_count(base_count), .sense_req(sense_req), .touch(touch), .wake(wake), .irq(irq));
